// ---- logic/eep_fifo.sv ----
// Purpose: Small valid/ready FIFO holding page data until the write cycle
// Assumes: Single clock
// Notes: Full and empty are exact; in_ready drops when full
`timescale 1ns/1ps
`default_nettype none
module eep_fifo #(
	parameter int WIDTH = 19,
	parameter int DEPTH = 16
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	// Pointers and fill count
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} eep_fifo_st_t;

	eep_fifo_st_t f_q;
	eep_fifo_st_t f_d;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push;
	logic pop;

	assign in_ready = (f_q.cnt != (AW+1)'(DEPTH));
	assign out_valid = (f_q.cnt != '0);
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem[f_q.rp];

	// Pointer arithmetic
	always_comb begin
		f_d = f_q;
		if (push) begin
			f_d.wp = f_q.wp + AW'(1);
		end
		if (pop) begin
			f_d.rp = f_q.rp + AW'(1);
		end
		f_d.cnt = f_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	// Storage has no reset; pointers do
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			f_q <= '0;
		end else begin
			f_q <= f_d;
		end
		if (push) begin
			mem[f_q.wp] <= in_data;
		end
	end
endmodule
`default_nettype wire

// ---- logic/eep_pkg.sv ----
// Purpose: Shared constants and carrier types for the two-wire EEPROM slave
// Assumes: 200 MHz mclk; serial clock and data sampled from the pins
// Notes: Address byte field offsets, bit counter and synchroniser reset values and the write cycle count live here
package eep_pkg;
	// mclk period in picoseconds
	localparam int CLK_PERIOD_PS = 5000;
	// Byte geometry
	localparam int BYTE_BITS = 8;
	localparam logic [3:0] BIT_CNT_RST = 4'h0;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	// Array shape: 128 pages of 16 bytes, 11-bit address
	localparam int PAGE_COUNT = 128;
	localparam int PAGE_BYTES = 16;
	localparam int ADDR_BITS = 11;
	localparam int MEM_DEPTH = PAGE_COUNT * PAGE_BYTES;
	// Address byte fields
	localparam logic [3:0] TYPE_ID = 4'ha;
	localparam int TYPE_MSB = 7;
	localparam int TYPE_LSB = 4;
	localparam int RW_POS = 0;
	// Self-timed write cycle of 5 ms; product kept inside 32 bits
	localparam int WRITE_TIME_MS = 5;
	localparam int WRITE_CYCLES =
		(WRITE_TIME_MS * 1000000) / (CLK_PERIOD_PS / 1000);
	// Write buffer shape
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_WIDTH = 19;
	// Synchroniser reset value (bus idle is high)
	localparam logic [2:0] SYNC_RST = 3'h7;

	// Word passed to the write buffer: address plus data
	typedef struct packed {
		logic [10:0] addr;
		logic [7:0] data;
	} eep_wr_word_t;

	// Filtered pin view from the sampler
	typedef struct packed {
		logic scl;
		logic sda;
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
	} eep_pins_t;

	// Link phases, one-hot
	typedef enum logic [5:0] {
		ST_IDLE = 6'b00_0001,
		ST_DEVADR = 6'b00_0010,
		ST_WORDADR = 6'b00_0100,
		ST_WRDATA = 6'b00_1000,
		ST_RDDATA = 6'b01_0000,
		ST_IGNORE = 6'b10_0000
	} eep_state_t;
endpackage

// ---- logic/eep_sampler.sv ----
// Purpose: Three-flop sampling of the serial clock and data pins
// Assumes: Pins are asynchronous to mclk
// Notes: A change counts once the second and third flops agree
`timescale 1ns/1ps
`default_nettype none
module eep_sampler (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic scl_i,
	input wire logic sda_i,
	output var eep_pkg::eep_pins_t pins
);
	// Whole state of the sampler
	typedef struct packed {
		logic [2:0] scl_sh;
		logic [2:0] sda_sh;
		logic scl_st;
		logic sda_st;
		eep_pkg::eep_pins_t out;
	} eep_smp_t;

	eep_smp_t s_q;
	eep_smp_t s_d;

	// Settled level update and edge detection
	always_comb begin
		s_d = s_q;
		s_d.scl_sh = {s_q.scl_sh[1:0], scl_i};
		s_d.sda_sh = {s_q.sda_sh[1:0], sda_i};
		s_d.out.scl_rise = 1'b0;
		s_d.out.scl_fall = 1'b0;
		s_d.out.start = 1'b0;
		s_d.out.stop = 1'b0;
		// Only flops two and three are compared; flop one is metastable
		if (s_q.scl_sh[1] == s_q.scl_sh[2]) begin
			s_d.scl_st = s_q.scl_sh[2];
		end
		if (s_q.sda_sh[1] == s_q.sda_sh[2]) begin
			s_d.sda_st = s_q.sda_sh[2];
		end
		s_d.out.scl_rise = s_d.scl_st & ~s_q.scl_st;
		s_d.out.scl_fall = ~s_d.scl_st & s_q.scl_st;
		// Data moving while clock stays high marks start or stop
		if (s_q.scl_st && s_d.scl_st) begin
			s_d.out.start = s_q.sda_st & ~s_d.sda_st;
			s_d.out.stop = ~s_q.sda_st & s_d.sda_st;
		end
		s_d.out.scl = s_d.scl_st;
		s_d.out.sda = s_d.sda_st;
	end

	// Register stage, idle bus reads high
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.scl_sh <= eep_pkg::SYNC_RST;
			s_q.sda_sh <= eep_pkg::SYNC_RST;
			s_q.scl_st <= 1'b1;
			s_q.sda_st <= 1'b1;
			s_q.out.scl <= 1'b1;
			s_q.out.sda <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign pins = s_q.out;
endmodule
`default_nettype wire

// ---- logic/eep_slave.sv ----
// Purpose: Two-wire slave link of a 16-kbit serial EEPROM with its array
// Assumes: Serial clock sampled by mclk; write cycle length is a parameter
// Notes: Data line is open-drain: only pulled low or released
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Sample data on clock rise, drive after fall
// - Bytes move most significant bit first
// - Nine clocks per byte, ninth is acknowledge
// - Data changes only while clock low
// - Data fall with clock high is start
// - Ignore everything until a start seen
// - Data rise with clock high is stop
// - Repeated start begins a new command
// - No byte limit between start and stop
// - Idle only when both lines high
// - Release after eighth, ack whole ninth
// - Master nack ends read; release line
// - Receiver releases line after ninth clock
// - Standby at reset, plain stop, write end
// - Recover by up to nine dummy clocks
// - Only pull data low, clock input only
// - 128 pages of 16 bytes, 11-bit address
// - Address byte: type 1010, high address, R/W
// - Ack matching type identifier, else nack
// - No ack while write cycle running
module eep_slave #(
	parameter int WRITE_CYCLES = eep_pkg::WRITE_CYCLES
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n,
	output logic standby,
	output logic write_busy,
	output logic bus_idle
);
	// Whole state of the link
	typedef struct packed {
		eep_pkg::eep_state_t st;
		logic [3:0] bitn;
		logic [7:0] sh;
		logic rw;
		logic [10:0] addr;
		logic [10:0] page_ptr;
		logic pull;
		logic ack_slot;
		logic nacked;
		logic wr_pend;
		logic busy;
		logic [31:0] wcnt;
		logic stby;
	} eep_core_t;

	eep_core_t c_q;
	eep_core_t c_d;
	eep_pkg::eep_pins_t pins;
	logic [7:0] mem [eep_pkg::MEM_DEPTH];
	logic [7:0] rd_byte;
	eep_pkg::eep_wr_word_t fin;
	eep_pkg::eep_wr_word_t fout;
	logic fin_valid;
	logic fin_ready;
	logic fout_valid;
	logic fout_ready;

	// Address of next byte within the same page
	function automatic logic [10:0] page_inc(input logic [10:0] a);
		page_inc = {a[10:4], a[3:0] + 4'h1};
	endfunction

	// Type identifier compare on an address byte
	function automatic logic type_ok(input logic [7:0] b);
		type_ok = (b[eep_pkg::TYPE_MSB:eep_pkg::TYPE_LSB] ==
			eep_pkg::TYPE_ID);
	endfunction

	// Pin sampler
	eep_sampler u_smp (
		.mclk(mclk),
		.rst_n(rst_n),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.pins(pins)
	);

	// Page buffer; drained only once the stop launches the write
	eep_fifo #(
		.WIDTH(eep_pkg::FIFO_WIDTH),
		.DEPTH(eep_pkg::FIFO_DEPTH)
	) u_fifo (
		.mclk(mclk),
		.rst_n(rst_n),
		.in_valid(fin_valid),
		.in_ready(fin_ready),
		.in_data(fin),
		.out_valid(fout_valid),
		.out_ready(fout_ready),
		.out_data(fout)
	);

	assign rd_byte = mem[c_q.addr];
	// Array takes the page while the write cycle runs
	assign fout_ready = c_q.busy;
	// Data byte pushed at its ninth clock rise; overflow past a
	// full page is refused by the buffer and simply dropped
	assign fin_valid = (c_q.st == eep_pkg::ST_WRDATA) && c_q.ack_slot &&
		pins.scl_rise && !c_q.nacked;
	assign fin.addr = c_q.page_ptr;
	assign fin.data = c_q.sh;

	// Protocol engine
	always_comb begin
		c_d = c_q;
		// Start wins over everything, also a repeated start
		if (pins.start) begin
			c_d.st = eep_pkg::ST_DEVADR;
			c_d.bitn = eep_pkg::BIT_CNT_RST;
			c_d.ack_slot = 1'b0;
			c_d.pull = 1'b0;
			c_d.nacked = 1'b0;
			c_d.stby = 1'b0;
		end else if (pins.stop) begin
			c_d.st = eep_pkg::ST_IDLE;
			c_d.pull = 1'b0;
			c_d.ack_slot = 1'b0;
			if (c_q.wr_pend) begin
				c_d.busy = 1'b1;
				c_d.wcnt = '0;
				c_d.wr_pend = 1'b0;
			end else if (!c_q.busy) begin
				c_d.stby = 1'b1;
			end
		end else if (c_q.st == eep_pkg::ST_IDLE ||
			c_q.st == eep_pkg::ST_IGNORE) begin
			// Nothing but start or stop is heard here
			c_d.pull = 1'b0;
		end else if (pins.scl_rise) begin
			// Sample on rise, MSB first
			if (!c_q.ack_slot) begin
				c_d.sh = {c_q.sh[6:0], pins.sda};
				c_d.bitn = c_q.bitn + 4'h1;
			end else if (c_q.st == eep_pkg::ST_RDDATA) begin
				// Master answer in ninth clock
				c_d.nacked = pins.sda;
			end
		end else if (pins.scl_fall) begin
			// Drive only after fall
			if (!c_q.ack_slot && c_q.bitn == eep_pkg::ACK_SLOT) begin
				// End of eighth clock: answer slot opens
				c_d.ack_slot = 1'b1;
				c_d.pull = 1'b0;
				case (c_q.st)
					eep_pkg::ST_DEVADR: begin
						c_d.rw = c_q.sh[eep_pkg::RW_POS];
						if (type_ok(c_q.sh) && !c_q.busy) begin
							c_d.pull = 1'b1;
							c_d.addr = {c_q.sh[3:1], c_q.addr[7:0]};
						end else begin
							c_d.nacked = 1'b1;
						end
					end
					eep_pkg::ST_WORDADR: begin
						c_d.pull = 1'b1;
						c_d.addr = {c_q.addr[10:8], c_q.sh};
						c_d.page_ptr = {c_q.addr[10:8], c_q.sh};
					end
					eep_pkg::ST_WRDATA: begin
						c_d.pull = 1'b1;
					end
					eep_pkg::ST_RDDATA: begin
						c_d.pull = 1'b0;
					end
					default: begin
						c_d.pull = 1'b0;
					end
				endcase
			end else if (c_q.ack_slot) begin
				// End of ninth clock: receiver lets go
				c_d.ack_slot = 1'b0;
				c_d.bitn = eep_pkg::BIT_CNT_RST;
				c_d.pull = 1'b0;
				if (c_q.nacked) begin
					c_d.st = eep_pkg::ST_IGNORE;
				end else begin
					case (c_q.st)
						eep_pkg::ST_DEVADR: begin
							if (c_q.rw) begin
								c_d.st = eep_pkg::ST_RDDATA;
							end else begin
								c_d.st = eep_pkg::ST_WORDADR;
							end
						end
						eep_pkg::ST_WORDADR: begin
							c_d.st = eep_pkg::ST_WRDATA;
						end
						eep_pkg::ST_WRDATA: begin
							c_d.wr_pend = 1'b1;
							c_d.page_ptr = page_inc(c_q.page_ptr);
						end
						eep_pkg::ST_RDDATA: begin
							// Next byte follows; no count limit
							c_d.addr = c_q.addr + 11'h001;
						end
						default: begin
							c_d.st = eep_pkg::ST_IGNORE;
						end
					endcase
				end
				// First read bit goes out right after this fall
				if (!c_q.nacked && (c_q.st == eep_pkg::ST_RDDATA ||
					(c_q.st == eep_pkg::ST_DEVADR && c_q.rw))) begin
					c_d.sh = (c_q.st == eep_pkg::ST_RDDATA) ?
						mem[c_q.addr + 11'h001] : rd_byte;
					c_d.pull = (c_q.st == eep_pkg::ST_RDDATA) ?
						~mem[c_q.addr + 11'h001][7] : ~rd_byte[7];
				end
			end else if (c_q.st == eep_pkg::ST_RDDATA) begin
				// Rise already rotated the byte; top bit is next
				c_d.pull = ~c_q.sh[7];
			end
		end
		// Self-timed write cycle
		if (c_q.busy) begin
			c_d.wcnt = c_q.wcnt + 32'h0000_0001;
			if (c_q.wcnt >= 32'(WRITE_CYCLES - 1) && !fout_valid) begin
				c_d.busy = 1'b0;
				if (c_d.st == eep_pkg::ST_IDLE) begin
					c_d.stby = 1'b1;
				end
			end
		end
	end

	// Registers
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			c_q <= '0;
			c_q.st <= eep_pkg::ST_IDLE;
			c_q.stby <= 1'b1;
		end else begin
			c_q <= c_d;
		end
		// Array update as the buffer drains
		if (fout_valid && fout_ready) begin
			mem[fout.addr] <= fout.data;
		end
	end

	// Open drain: drive zero, enable low when pulling
	assign sda_o = 1'b0;
	assign sda_oe_n = ~c_q.pull;
	assign standby = c_q.stby;
	assign write_busy = c_q.busy;
	assign bus_idle = pins.scl & pins.sda;

	// Assertions; each pins one promise of the link to its logic
	a_only_pull_low: assert property (
		@(posedge mclk) disable iff (!rst_n)
		!sda_oe_n |-> sda_o == 1'b0)
		else $error("data line driven high");
	// Start and stop may move the line while the clock is high
	a_change_clk_low: assert property (
		@(posedge mclk) disable iff (!rst_n)
		$changed(sda_oe_n) |-> !pins.scl || $past(pins.start) ||
		$past(pins.stop))
		else $error("data changed while clock high");
	a_busy_no_ack: assert property (
		@(posedge mclk) disable iff (!rst_n)
		c_q.busy && c_q.st == eep_pkg::ST_DEVADR && c_q.ack_slot
		|-> sda_oe_n)
		else $error("acked during write cycle");
	a_start_devadr: assert property (
		@(posedge mclk) disable iff (!rst_n)
		pins.start |=> c_q.st == eep_pkg::ST_DEVADR &&
		c_q.bitn == eep_pkg::BIT_CNT_RST)
		else $error("start not taken");
	a_stop_idle: assert property (
		@(posedge mclk) disable iff (!rst_n)
		pins.stop && !pins.start |=> c_q.st == eep_pkg::ST_IDLE &&
		sda_oe_n)
		else $error("stop not taken");
	a_ignore_quiet: assert property (
		@(posedge mclk) disable iff (!rst_n)
		c_q.st == eep_pkg::ST_IGNORE |-> sda_oe_n)
		else $error("line pulled while ignoring");
	a_ninth_release: assert property (
		@(posedge mclk) disable iff (!rst_n)
		c_q.ack_slot && pins.scl_fall && c_q.st != eep_pkg::ST_RDDATA
		&& c_q.st != eep_pkg::ST_DEVADR |=> sda_oe_n)
		else $error("line not released after ninth");
	a_bad_type_nack: assert property (
		@(posedge mclk) disable iff (!rst_n)
		c_q.st == eep_pkg::ST_DEVADR && !c_q.ack_slot && pins.scl_fall
		&& c_q.bitn == eep_pkg::ACK_SLOT && !type_ok(c_q.sh)
		&& !pins.start && !pins.stop |=> sda_oe_n ##1 c_q.nacked)
		else $error("bad type acknowledged");
	// Stop is only ever seen with both lines high
	a_idle_lines: assert property (
		@(posedge mclk) disable iff (!rst_n)
		pins.stop |-> bus_idle)
		else $error("stop seen on a busy bus");
	// Receiver keeps the line low over the whole ninth high phase
	a_ack_held: assert property (
		@(posedge mclk) disable iff (!rst_n)
		c_q.ack_slot && pins.scl && !c_q.nacked &&
		c_q.st != eep_pkg::ST_RDDATA |-> !sda_oe_n)
		else $error("acknowledge not held in ninth clock");
	// Transmitter lets go at the eighth fall so the master can answer
	a_tx_release: assert property (
		@(posedge mclk) disable iff (!rst_n)
		c_q.st == eep_pkg::ST_RDDATA && c_q.ack_slot |-> sda_oe_n)
		else $error("line held in master answer clock");
	// First read bit on the line is the top bit of the byte
	a_msb_first: assert property (
		@(posedge mclk) disable iff (!rst_n)
		c_q.st == eep_pkg::ST_DEVADR && c_q.ack_slot && c_q.rw &&
		!c_q.nacked && pins.scl_fall |=> sda_oe_n == $past(rd_byte[7]))
		else $error("read byte not sent top bit first");
	// Write cycle never ends before its full count
	a_wr_cycle_len: assert property (
		@(posedge mclk) disable iff (!rst_n)
		$fell(write_busy) |-> c_q.wcnt >= 32'(WRITE_CYCLES))
		else $error("write cycle cut short");
	// Standby follows the end of a write on a quiet bus
	a_wr_end_stby: assert property (
		@(posedge mclk) disable iff (!rst_n)
		$fell(write_busy) && c_q.st == eep_pkg::ST_IDLE |-> standby)
		else $error("no standby after write cycle");
	c_ack_given: cover property (@(posedge mclk) disable iff (!rst_n)
		c_q.ack_slot && !sda_oe_n);
	c_write_run: cover property (@(posedge mclk) disable iff (!rst_n)
		$rose(c_q.busy));
	c_read_nack: cover property (@(posedge mclk) disable iff (!rst_n)
		c_q.st == eep_pkg::ST_RDDATA && c_d.st == eep_pkg::ST_IGNORE);
	c_poll_refused: cover property (@(posedge mclk) disable iff (!rst_n)
		c_q.busy && c_q.st == eep_pkg::ST_IGNORE);
	c_rep_start: cover property (@(posedge mclk) disable iff (!rst_n)
		pins.start && c_q.st == eep_pkg::ST_WRDATA);
endmodule
`default_nettype wire

// ---- tb/eep_master_model.sv ----
// Purpose: Behavioural two-wire bus master that drives the serial clock
// Assumes: Data wire resolved outside with a pull-up; 1 = released
// Notes: 48 ns clock, 30 ns low and 18 ns high; clock idles high
`timescale 1ns/1ps
`default_nettype none
module eep_master_model (
	output logic scl,
	output logic sda_m,
	input wire logic sda_w
);
	// Data-line moves seen inside one high clock phase
	int bad_hold = 0;

	// Both lines released at time zero
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end

	// Start from idle lines, clock left low
	task automatic go();
		#20 sda_m = 1'b0;
		#20 scl = 1'b0;
	endtask

	// Stop from a low clock, lines left idle
	task automatic halt();
		#10 sda_m = 1'b0;
		#20 scl = 1'b1;
		#20 sda_m = 1'b1;
		// Tail covers the sampler delay so checks see the stop
		#40;
	endtask

	// Clock pulled low with data left high; no start is made
	task automatic drop();
		#20 scl = 1'b0;
	endtask

	// Repeated start from a low clock
	task automatic rs();
		#10 sda_m = 1'b1;
		#20 scl = 1'b1;
		#20 sda_m = 1'b0;
		#20 scl = 1'b0;
	endtask

	// One clock; the wire is sampled twice while high to catch moves
	task automatic bit_x(input logic b, output logic r);
		logic s1;
		#10 sda_m = b;
		#20 scl = 1'b1;
		#4 s1 = sda_w;
		#10 r = sda_w;
		// Any move while high breaks the hold window
		if (s1 !== r)
			bad_hold++;
		#4 scl = 1'b0;
	endtask

	// Eight bits MSB first, then the ninth answer clock
	task automatic xb(input logic [7:0] d, input logic a_in,
		output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], q[i]);
		end
		bit_x(a_in, a);
	endtask
endmodule
`default_nettype wire

// ---- tb/tb_eep_slave.sv ----
// Purpose: Self-checking bench for the two-wire EEPROM slave link
// Assumes: Write cycle shortened to 200 mclk through the parameter
// Notes: Pull-up on the data wire; the master model owns the clock
`timescale 1ns/1ps
`default_nettype none
module tb_eep_slave;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic scl;
	logic sda_m;
	logic sda_o;
	logic sda_oe_n;
	logic standby;
	logic write_busy;
	logic bus_idle;
	// Resolved open-drain data wire, high when nobody pulls
	wire sda_w = sda_m & (sda_oe_n | sda_o);
	int err_count = 0;
	int n_checks = 0;
	// Page data written at 0x13E, wrapping to 0x130 in the page
	logic [7:0] wd [5] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55};

	// 200 MHz clock
	always #2.5 mclk = ~mclk;

	eep_slave #(.WRITE_CYCLES(200)) u_eep_slave (
		.mclk(mclk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_w),
		.sda_o(sda_o), .sda_oe_n(sda_oe_n), .standby(standby),
		.write_busy(write_busy), .bus_idle(bus_idle)
	);

	eep_master_model u_eep_master_model (
		.scl(scl), .sda_m(sda_m), .sda_w(sda_w)
	);

	// One comparison, reported at once on mismatch
	task automatic chk(input string nm, input logic [7:0] seen,
		input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Verdict and end of run
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Send a byte with the line released in the answer clock
	task automatic sb(input logic [7:0] d, output logic a);
		logic [7:0] q;
		u_eep_master_model.xb(d, 1'b1, q, a);
	endtask

	// Idle outputs straight after reset
	task automatic t_reset();
		chk("standby", standby, 1);
		chk("busy", write_busy, 0);
		chk("idle", bus_idle, 1);
		chk("oe_n", sda_oe_n, 1);
		chk("sda_o", sda_o, 0);
	endtask

	// A byte clocked without a start must not be answered
	task automatic t_no_start();
		logic a;
		u_eep_master_model.drop();
		sb(8'hA0, a);
		chk("nostart_ack", a, 1);
		u_eep_master_model.halt();
		chk("nostart_stby", standby, 1);
	endtask

	// Wrong type id refused, then the rest ignored until stop
	task automatic t_bad_id();
		logic a;
		u_eep_master_model.go();
		sb(8'h50, a);
		chk("badid_ack", a, 1);
		sb(8'hA0, a);
		chk("ignored_ack", a, 1);
		u_eep_master_model.halt();
		chk("badid_stby", standby, 1);
	endtask

	// Five-byte page write across the page end, then polling
	task automatic t_write();
		logic a;
		int i;
		u_eep_master_model.go();
		sb(8'hA2, a);
		chk("wr_dev_ack", a, 0);
		chk("wake", standby, 0);
		sb(8'h3E, a);
		chk("wr_word_ack", a, 0);
		for (i = 0; i < 5; i++) begin
			sb(wd[i], a);
			chk("wr_data_ack", a, 0);
		end
		u_eep_master_model.halt();
		repeat (10) @(posedge mclk);
		chk("busy_on", write_busy, 1);
		chk("busy_stby", standby, 0);
		// Polling while the cycle runs is refused
		u_eep_master_model.go();
		sb(8'hA2, a);
		chk("poll_busy", a, 1);
		u_eep_master_model.halt();
		// Bounded wait for the cycle to finish
		for (i = 0; i < 400; i++) begin
			if (write_busy === 1'b0)
				break;
			@(posedge mclk);
		end
		chk("busy_off", write_busy, 0);
		chk("end_stby", standby, 1);
		u_eep_master_model.go();
		sb(8'hA2, a);
		chk("poll_done", a, 0);
		u_eep_master_model.halt();
		chk("plain_stop", standby, 1);
	endtask

	// Random read through a repeated start, nack on the last byte
	task automatic t_read(input logic [7:0] wa, input int n, input int k);
		logic a;
		logic [7:0] q;
		u_eep_master_model.go();
		sb(8'hA2, a);
		sb(wa, a);
		u_eep_master_model.rs();
		sb(8'hA3, a);
		chk("rd_dev_ack", a, 0);
		for (int i = 0; i < n; i++) begin
			u_eep_master_model.xb(8'hFF, i == n - 1, q, a);
			chk("rd_data", q, wd[k + i]);
		end
		u_eep_master_model.halt();
		chk("rd_release", sda_oe_n, 1);
		chk("rd_stby", standby, 1);
	endtask

	// Address byte cut before its answer clock, then dummy clocks
	task automatic t_recover();
		logic r;
		logic [7:0] d;
		int k;
		d = 8'hA2;
		u_eep_master_model.go();
		for (int i = 7; i >= 0; i--) begin
			u_eep_master_model.bit_x(d[i], r);
		end
		for (k = 1; k < 9; k++) begin
			u_eep_master_model.bit_x(1'b1, r);
			if (r === 1'b1)
				break;
		end
		chk("dummy_clocks", k[7:0], 2);
		u_eep_master_model.rs();
		sb(8'hA2, r);
		chk("recover_ack", r, 0);
		u_eep_master_model.halt();
		chk("idle_again", bus_idle, 1);
	endtask

	// Reset, then the scenarios in turn
	initial begin
		repeat (5) @(posedge mclk);
		@(negedge mclk) rst_n = 1'b1;
		repeat (8) @(posedge mclk);
		t_reset();
		t_no_start();
		t_bad_id();
		t_write();
		t_read(8'h30, 3, 2);
		t_read(8'h3E, 2, 0);
		t_recover();
		chk("hold_high", u_eep_master_model.bad_hold[7:0], 0);
		end_of_test();
	end

	// Watchdog well beyond the expected 13 us of traffic
	initial begin
		#200000;
		err_count++;
		end_of_test();
	end
endmodule
`default_nettype wire
